// *** include/lst_pkg.sv ***
// lst_pkg: constants shared by the lcd sync timing block
package lst_pkg;
  localparam int unsigned LST_CHAR_PIX = 8;
  localparam int unsigned LST_ADDR_W   = 12;
  localparam int unsigned LST_IDX_W    = 10;
  // register indices; byte address is four times the index
  localparam logic [9:0] LST_IDX_CTRL    = 10'h030;
  localparam logic [9:0] LST_IDX_HDISP   = 10'h032;
  localparam logic [9:0] LST_IDX_HBLANK  = 10'h034;
  localparam logic [9:0] LST_IDX_LSTART  = 10'h035;
  localparam logic [9:0] LST_IDX_LWIDTH  = 10'h036;
  localparam logic [9:0] LST_IDX_VH_LO   = 10'h038;
  localparam logic [9:0] LST_IDX_VH_HI   = 10'h039;
  localparam logic [9:0] LST_IDX_VBLANK  = 10'h03a;
  localparam logic [9:0] LST_IDX_FSTART  = 10'h03b;
  localparam logic [9:0] LST_IDX_FWIDTH  = 10'h03c;
  localparam logic [9:0] LST_IDX_IRQ_ST  = 10'h0f0;
  localparam logic [9:0] LST_IDX_IRQ_EN  = 10'h0f1;
  localparam logic [9:0] LST_IDX_IRQ_CLR = 10'h0f2;
  // field positions
  localparam int unsigned LST_CTRL_RUN     = 0;
  localparam int unsigned LST_CTRL_PASSIVE = 1;
  localparam int unsigned LST_POL_BIT      = 7;
  localparam int unsigned LST_VSTAT_BIT    = 7;
  localparam int unsigned LST_IRQ_VB       = 0;
  localparam int unsigned LST_IRQ_FRAME    = 1;
  // reset values
  localparam logic [6:0] LST_RST_HDISP  = 7'h4f;
  localparam logic [4:0] LST_RST_HBLANK = 5'h03;
  localparam logic [4:0] LST_RST_LSTART = 5'h00;
  localparam logic [3:0] LST_RST_LWIDTH = 4'h0;
  localparam logic [9:0] LST_RST_VH     = 10'h0ef;
  localparam logic [5:0] LST_RST_VBLANK = 6'h03;
  localparam logic [5:0] LST_RST_FSTART = 6'h00;
  localparam logic [2:0] LST_RST_FWIDTH = 3'h0;
endpackage

// *** core/lst_char_div.sv ***
// lst_char_div: pixel-group enable divider
`timescale 1ns/1ps
`default_nettype none

module lst_char_div
  import lst_pkg::*;
#(
  parameter int unsigned DIV = LST_CHAR_PIX
) (
  input  wire logic clock_i,
  input  wire logic resetn_i,
  input  wire logic run_i,
  output logic      tick_o
);
  localparam int unsigned CW = (DIV > 2) ? $clog2(DIV) : 1;

  if (DIV < 2 || DIV > 256) begin : g_chk
    $error("lst_char_div: DIV out of range");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } lst_div_t;

  lst_div_t s;
  lst_div_t next_s;

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (!run_i) begin
      next_s.cnt = '0;
    end else if (s.cnt == CW'(DIV - 1)) begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = CW'(s.cnt + 1'b1);
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;
endmodule

`default_nettype wire

// *** core/lst_window.sv ***
// lst_window: tells whether a count lies in [first, first+len)
`timescale 1ns/1ps
`default_nettype none

module lst_window #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] count_i,
  input  wire logic [W-1:0] first_i,
  input  wire logic [W-1:0] len_i,
  output logic              inside_o
);
  if (W < 2) begin : g_chk
    $error("lst_window: W too small");
  end

  logic [W:0] last;

  // one extra bit so first+len cannot wrap back into range
  assign last     = {1'b0, first_i} + {1'b0, len_i};
  assign inside_o = (count_i >= first_i) && ({1'b0, count_i} < last);
endmodule

`default_nettype wire

// *** core/lst_timing_regs.sv ***
// lst_timing_regs: apb registers and line/frame sync generator
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module lst_timing_regs
  import lst_pkg::*;
#(
  parameter int unsigned CHAR_PIX = LST_CHAR_PIX
) (
  input  wire logic                  clock_i,
  input  wire logic                  resetn_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [LST_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  output logic                       line_sync_out_o,
  output logic                       frame_sync_out_o,
  output logic                       irq_o
);
  if (CHAR_PIX < 2 || CHAR_PIX > 16) begin : g_chk
    $error("lst_timing_regs: CHAR_PIX out of range");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        run;
    logic        passive;
    logic [6:0]  hdisp;
    logic [4:0]  hblank;
    logic [4:0]  lstart;
    logic [3:0]  lwidth;
    logic        lpol;
    logic [9:0]  vheight;
    logic [5:0]  vblank;
    logic [5:0]  fstart;
    logic [2:0]  fwidth;
    logic        fpol;
    logic [1:0]  ien;
    logic [1:0]  ist;
    logic [7:0]  hcnt;
    logic [10:0] vcnt;
    logic        in_vblank;
    logic        line_sync;
    logic        frame_sync;
    logic        irq;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } lst_state_t;

  lst_state_t s;
  lst_state_t next_s;

  logic [LST_IDX_W-1:0] idx;
  logic                 hit;
  logic [31:0]          rd_word;
  logic                 wr_fire;
  logic [1:0]           clr;
  logic [1:0]           ev;
  logic                 char_tick;
  logic                 line_end;
  logic [7:0]           htotal;
  logic [10:0]          vtotal;
  logic [7:0]           l_first;
  logic [7:0]           l_len;
  logic [10:0]          f_first;
  logic [10:0]          f_len;
  logic                 l_in;
  logic                 f_in;
  logic                 l_lvl;
  logic                 f_lvl;

  // ---------------------------------------------------------------
  // timing arithmetic
  // ---------------------------------------------------------------
  assign htotal  = 8'(s.hdisp) + 8'(s.hblank) + 8'h01;
  assign vtotal  = 11'(s.vheight) + 11'(s.vblank) + 11'h001;
  // line sync opens (start+1) groups into horizontal blank
  assign l_first = 8'(s.hdisp) + 8'(s.lstart) + 8'h02;
  assign l_len   = 8'(s.lwidth) + 8'h01;
  assign f_first = 11'(s.vheight) + 11'(s.fstart) + 11'h002;
  assign f_len   = 11'(s.fwidth) + 11'h001;
  // active level: passive panels see the opposite sense
  assign l_lvl   = s.lpol ^ s.passive;
  assign f_lvl   = s.fpol ^ s.passive;
  assign line_end = char_tick && (s.hcnt == htotal);

  lst_char_div #(
    .DIV (CHAR_PIX)
  ) u_div (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .run_i    (s.run),
    .tick_o   (char_tick)
  );

  lst_window #(
    .W (8)
  ) u_lwin (
    .count_i  (s.hcnt),
    .first_i  (l_first),
    .len_i    (l_len),
    .inside_o (l_in)
  );

  lst_window #(
    .W (11)
  ) u_fwin (
    .count_i  (s.vcnt),
    .first_i  (f_first),
    .len_i    (f_len),
    .inside_o (f_in)
  );

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  assign idx     = paddr_i[LST_ADDR_W-1:2];
  assign wr_fire = psel_i && penable_i && s.ready && pwrite_i && hit;
  assign clr     = (wr_fire && idx == LST_IDX_IRQ_CLR) ? pwdata_i[1:0] : 2'h0;

  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0;
    case (idx)
      LST_IDX_CTRL:    rd_word = 32'({s.passive, s.run});
      LST_IDX_HDISP:   rd_word = 32'(s.hdisp);
      LST_IDX_HBLANK:  rd_word = 32'(s.hblank);
      LST_IDX_LSTART:  rd_word = 32'(s.lstart);
      LST_IDX_LWIDTH:  rd_word = 32'({s.lpol, 3'h0, s.lwidth});
      LST_IDX_VH_LO:   rd_word = 32'(s.vheight[7:0]);
      LST_IDX_VH_HI:   rd_word = 32'(s.vheight[9:8]);
      LST_IDX_VBLANK:  rd_word = 32'({s.in_vblank, 1'b0, s.vblank});
      LST_IDX_FSTART:  rd_word = 32'(s.fstart);
      LST_IDX_FWIDTH:  rd_word = 32'({s.fpol, 4'h0, s.fwidth});
      LST_IDX_IRQ_ST:  rd_word = 32'(s.ist);
      LST_IDX_IRQ_EN:  rd_word = 32'(s.ien);
      LST_IDX_IRQ_CLR: rd_word = 32'h0;
      default:         hit = 1'b0;
    endcase
    // a misaligned access must not leak the neighbouring register
    if (paddr_i[1:0] != 2'h0) begin
      hit     = 1'b0;
      rd_word = 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s        = s;
    next_s.ready  = 1'b0;
    next_s.slverr = 1'b0;
    ev            = 2'h0;
    // answer one cycle into the access phase
    if (psel_i && penable_i && !s.ready) begin
      next_s.ready  = 1'b1;
      next_s.slverr = !hit;
      next_s.rdata  = rd_word;
    end
    if (wr_fire) begin
      case (idx)
        LST_IDX_CTRL: begin
          next_s.run     = pwdata_i[LST_CTRL_RUN];
          next_s.passive = pwdata_i[LST_CTRL_PASSIVE];
        end
        LST_IDX_HDISP:  next_s.hdisp = pwdata_i[6:0];
        LST_IDX_HBLANK: next_s.hblank = pwdata_i[4:0];
        LST_IDX_LSTART: next_s.lstart = pwdata_i[4:0];
        LST_IDX_LWIDTH: begin
          next_s.lwidth = pwdata_i[3:0];
          next_s.lpol   = pwdata_i[LST_POL_BIT];
        end
        LST_IDX_VH_LO:  next_s.vheight[7:0] = pwdata_i[7:0];
        LST_IDX_VH_HI:  next_s.vheight[9:8] = pwdata_i[1:0];
        LST_IDX_VBLANK: next_s.vblank = pwdata_i[5:0];
        LST_IDX_FSTART: next_s.fstart = pwdata_i[5:0];
        LST_IDX_FWIDTH: begin
          next_s.fwidth = pwdata_i[2:0];
          next_s.fpol   = pwdata_i[LST_POL_BIT];
        end
        LST_IDX_IRQ_EN: next_s.ien = pwdata_i[1:0];
        default: ;
      endcase
    end
    // raster counters: group count per line, line count per frame
    if (!s.run) begin
      next_s.hcnt = 8'h00;
      next_s.vcnt = 11'h000;
    end else if (char_tick) begin
      next_s.hcnt = line_end ? 8'h00 : 8'(s.hcnt + 8'h01);
      if (line_end) begin
        ev[LST_IRQ_VB]    = (s.vcnt == 11'(s.vheight));
        ev[LST_IRQ_FRAME] = (s.vcnt == vtotal);
        next_s.vcnt = (s.vcnt == vtotal) ? 11'h000 : 11'(s.vcnt + 11'h001);
      end
    end
    next_s.in_vblank  = (next_s.vcnt > 11'(s.vheight));
    // idle panel sits at the inactive level
    next_s.line_sync  = (s.run && l_in) ? l_lvl : !l_lvl;
    next_s.frame_sync = (s.run && f_in) ? f_lvl : !f_lvl;
    // a new event beats a clear in the same cycle
    next_s.ist = (s.ist & ~clr) | ev;
    next_s.irq = |(next_s.ist & next_s.ien);
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s         <= '0;
      s.hdisp   <= LST_RST_HDISP;
      s.hblank  <= LST_RST_HBLANK;
      s.lstart  <= LST_RST_LSTART;
      s.lwidth  <= LST_RST_LWIDTH;
      s.vheight <= LST_RST_VH;
      s.vblank  <= LST_RST_VBLANK;
      s.fstart  <= LST_RST_FSTART;
      s.fwidth  <= LST_RST_FWIDTH;
      s.line_sync  <= 1'b1;
      s.frame_sync <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_o         = s.rdata;
  assign pready_o         = s.ready;
  assign pslverr_o        = s.slverr;
  assign line_sync_out_o  = s.line_sync;
  assign frame_sync_out_o = s.frame_sync;
  assign irq_o            = s.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // checks other than the two idle-level checks hold only after two frame ends with no register write
  logic [1:0]  settled;
  logic [8:0]  lw_cnt;
  logic [11:0] pc_cnt;
  logic [10:0] ln_cnt;
  logic [3:0]  fl_cnt;
  logic        l_act;
  logic        f_act;

  assign l_act = (line_sync_out_o == l_lvl);
  assign f_act = (frame_sync_out_o == f_lvl);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      settled <= 2'h0;
      lw_cnt  <= 9'h000;
      pc_cnt  <= 12'h000;
      ln_cnt  <= 11'h000;
      fl_cnt  <= 4'h0;
    end else begin
      if (wr_fire) begin
        settled <= 2'h0;
      end else if (ev[LST_IRQ_FRAME] && settled != 2'h2) begin
        settled <= 2'(settled + 2'h1);
      end
      lw_cnt <= l_act ? 9'(lw_cnt + 9'h001) : 9'h000;
      pc_cnt <= line_end ? 12'h000 : 12'(pc_cnt + 12'h001);
      if (line_end) begin
        ln_cnt <= (next_s.in_vblank != s.in_vblank) ? 11'h000 : 11'(ln_cnt + 11'h001);
      end
      if (!f_act) begin
        fl_cnt <= 4'h0;
      end else if (line_end) begin
        fl_cnt <= 4'(fl_cnt + 4'h1);
      end
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking

  default disable iff (!resetn_i || settled != 2'h2);

  a_lsync_len: assert property ($fell(l_act) |->
    lw_cnt == 9'(({5'h0, s.lwidth} + 9'h001) * 9'(CHAR_PIX)))
    else $error("line sync width wrong");

  a_lsync_max: assert property (lw_cnt <= 9'(16 * CHAR_PIX))
    else $error("line sync too long");

  a_vdisp_lines: assert property ($rose(s.in_vblank) |->
    $past(ln_cnt) == 11'(s.vheight))
    else $error("display height wrong");

  a_vstat_read: assert property (
    psel_i && penable_i && !pready_o && !pwrite_i && hit && idx == LST_IDX_VBLANK
    |=> prdata_o[LST_VSTAT_BIT] == $past(s.in_vblank))
    else $error("vblank status read wrong");

  a_vblank_lines: assert property ($fell(s.in_vblank) |->
    $past(ln_cnt) == 11'(s.vblank))
    else $error("vertical blank length wrong");

  a_fsync_start: assert property ($rose(f_act) |-> s.vcnt == f_first)
    else $error("frame sync start wrong");

  a_fsync_lines: assert property ($fell(f_act) |->
    fl_cnt == 4'({1'b0, s.fwidth} + 4'h1))
    else $error("frame sync width wrong");

  a_fsync_pol: assert property (disable iff (!resetn_i)
    !s.run ##1 (!s.run && $stable(f_lvl)) |-> frame_sync_out_o == !f_lvl)
    else $error("frame sync idle level wrong");

  a_lsync_pol: assert property (disable iff (!resetn_i)
    !s.run ##1 (!s.run && $stable(l_lvl)) |-> line_sync_out_o == !l_lvl)
    else $error("line sync idle level wrong");

  a_line_period: assert property (line_end && $past(s.run, 2) |->
    pc_cnt == 12'(({4'h0, htotal} + 12'h001) * 12'(CHAR_PIX) - 12'h001))
    else $error("line period wrong");

  a_vline_step: assert property (s.run && $changed(s.vcnt) |->
    $past(line_end))
    else $error("line counter stepped off a line end");

  c_frame_start: cover property (ev[LST_IRQ_FRAME]);
  c_irq_raised: cover property ($rose(irq_o));
  c_bad_addr: cover property (pready_o && pslverr_o);
  c_fsync_pulse: cover property ($fell(f_act));
endmodule

`default_nettype wire

// *** dv/lst_panel_model.sv ***
// lst_panel_model: panel side that measures the sync pulses it receives
`timescale 1ns/1ps
`default_nettype none

module lst_panel_model (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        line_i,
  input  wire logic        frame_i,
  input  wire logic        lvl_i,
  output logic      [31:0] lw_o,
  output logic      [31:0] lp_o,
  output logic             ldone_o,
  output logic      [31:0] fw_o,
  output logic      [31:0] fp_o,
  output logic             fdone_o
);
  // ----------------------------------------------------------------
  // pulse measurement
  // ----------------------------------------------------------------
  // the panel only listens; its active level is a board choice, so the
  // bench hands it over; first period after a restart is stale
  logic [31:0] cyc;
  logic [31:0] ls;
  logic [31:0] fs;
  logic        la;
  logic        fa;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cyc     <= 32'h0;
      ls      <= 32'h0;
      fs      <= 32'h0;
      la      <= 1'b0;
      fa      <= 1'b0;
      lw_o    <= 32'h0;
      lp_o    <= 32'h0;
      fw_o    <= 32'h0;
      fp_o    <= 32'h0;
      ldone_o <= 1'b0;
      fdone_o <= 1'b0;
    end else begin
      cyc     <= cyc + 32'h1;
      la      <= (line_i == lvl_i);
      fa      <= (frame_i == lvl_i);
      ldone_o <= (line_i != lvl_i) && la;
      fdone_o <= (frame_i != lvl_i) && fa;
      if ((line_i == lvl_i) && !la) begin
        lp_o <= cyc - ls;
        ls   <= cyc;
      end
      if ((line_i != lvl_i) && la) begin
        lw_o <= cyc - ls;
      end
      if ((frame_i == lvl_i) && !fa) begin
        fp_o <= cyc - fs;
        fs   <= cyc;
      end
      if ((frame_i != lvl_i) && fa) begin
        fw_o <= cyc - fs;
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/test_lst_timing_regs.sv ***
// test_lst_timing_regs: self-checking bench for the lcd sync timing block
`timescale 1ns/1ps
`default_nettype none

module test_lst_timing_regs
  import lst_pkg::*;
();
  localparam int CP = LST_CHAR_PIX;
  typedef struct { logic rd; logic [31:0] d; logic e; } lst_bus_t;
  typedef struct { int w; int p; bit chkp; } lst_pulse_t;
  logic        clk, rstn, psel, pen, pwr, lvl;
  logic        pready, pslverr, lsync, fsync, irq, ldone, fdone;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lw, lp, fw, fp, r;
  int          mismatches, samples_checked, seed, n;
  lst_bus_t    aq[$];
  lst_pulse_t  lq[$], fq[$];
  lst_bus_t    mb;
  lst_pulse_t  mp;
  logic [11:0] rv_a[7] = '{12'h0c0, 12'h0c8, 12'h0d0, 12'h0d8, 12'h0e0, 12'h0e4, 12'h3c0};
  logic [31:0] rv_d[7] = '{32'h0, 32'h4f, 32'h3, 32'h0, 32'hef, 32'h0, 32'h0};
  logic [11:0] rw_a[6] = '{12'h0d4, 12'h0d8, 12'h0e0, 12'h0e4, 12'h0ec, 12'h0f0};
  logic [31:0] rw_m[6] = '{32'h1f, 32'h8f, 32'hff, 32'h3, 32'h3f, 32'h87};

  lst_timing_regs u_lst_timing_regs (
    .clock_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .line_sync_out_o(lsync), .frame_sync_out_o(fsync), .irq_o(irq));
  lst_panel_model u_lst_panel_model (
    .clock_i(clk), .resetn_i(rstn), .line_i(lsync), .frame_i(fsync), .lvl_i(lvl),
    .lw_o(lw), .lp_o(lp), .ldone_o(ldone), .fw_o(fw), .fp_o(fp), .fdone_o(fdone));

  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    $display("timeout");
    end_of_test();
  endtask

  // ----------------------------------------------------------------
  // apb master; every answer is noted for the monitor
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] ex, input logic er);
    int k;
    aq.push_back('{~w, ex, er});
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) hang();
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0, ex, 1'b0);
  endtask
  task automatic cycles(input int c);
    repeat (c) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // timing setup: hdisp 1, height 4 lines, blank 8 lines, frame start 1 width 1
  // ----------------------------------------------------------------
  task automatic run_cfg(input bit pas, input bit pol, input int lwd, input int hb);
    int p;
    logic [31:0] pb;
    pb = pol ? 32'h80 : 32'h0;
    p = (hb + 3) * CP;
    // panel type set while stopped, so the idle level already matches the panel
    wr(12'h0c0, {30'h0, pas, 1'b0});
    wr(12'h0d0, hb);
    wr(12'h0d4, 32'h0);
    wr(12'h0d8, pb | lwd);
    wr(12'h0e0, 32'h3);
    wr(12'h0e4, 32'h0);
    wr(12'h0e8, 32'h7);
    wr(12'h0ec, 32'h1);
    wr(12'h0f0, pb | 32'h1);
    wr(12'h0c8, 32'h1);
    lvl <= pol ^ pas;
    cycles(4);
    lq.push_back('{(lwd + 1) * CP, p, 1'b0});
    lq.push_back('{(lwd + 1) * CP, p, 1'b1});
    fq.push_back('{2 * p, 12 * p, 1'b0});
    fq.push_back('{2 * p, 12 * p, 1'b1});
    wr(12'h0c0, {30'h0, pas, 1'b1});
    n = 0;
    while ((lq.size() + fq.size()) > 0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) hang();
    $display("test sync pas=%0d pol=%0d width=%0d done", pas, pol, lwd);
  endtask

  // ----------------------------------------------------------------
  // monitor: oldest note against each result seen
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (pready === 1'b1 && aq.size() > 0) begin
      mb = aq.pop_front();
      if (mb.rd) cmp("prdata", mb.d, prdata);
      cmp("pslverr", {31'h0, mb.e}, {31'h0, pslverr});
    end
    if (ldone === 1'b1 && lq.size() > 0) begin
      mp = lq.pop_front();
      cmp("line width", mp.w, lw);
      if (mp.chkp) cmp("line period", mp.p, lp);
    end
    if (fdone === 1'b1 && fq.size() > 0) begin
      mp = fq.pop_front();
      cmp("frame width", mp.w, fw);
      if (mp.chkp) cmp("frame period", mp.p, fp);
    end
  end

  initial begin
    clk    = 1'b0;
    rstn   = 1'b0;
    psel   = 1'b0;
    pen    = 1'b0;
    pwr    = 1'b0;
    paddr  = 12'h0;
    pwdata = 32'h0;
    lvl    = 1'b0;
    seed   = 32'h968f;
    cycles(10);
    rstn <= 1'b1;
    foreach (rv_a[i]) rd(rv_a[i], rv_d[i]);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      wr(rw_a[i], r);
      rd(rw_a[i], r & rw_m[i]);
    end
    bus(1'b0, 12'h3fc, 32'h0, 32'h0, 1'b1);
    bus(1'b1, 12'h3fc, 32'h5, 32'h0, 1'b1);
    bus(1'b0, 12'h0d9, 32'h0, 32'h0, 1'b1);
    $display("test register access done");
    run_cfg(1'b0, 1'b1, 1, 3);
    // clear first so the enable cannot fire on a stale event
    wr(12'h3c8, 32'h3);
    wr(12'h3c4, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) hang();
    rd(12'h0e8, 32'h87);
    wr(12'h3c8, 32'h3);
    cycles(2);
    cmp("irq", 32'h0, {31'h0, irq});
    cycles(400);
    rd(12'h0e8, 32'h07);
    wr(12'h3c4, 32'h0);
    cycles(600);
    cmp("irq masked", 32'h0, {31'h0, irq});
    rd(12'h3c0, 32'h3);
    wr(12'h3c8, 32'h3);
    rd(12'h3c0, 32'h0);
    rd(12'h3c8, 32'h0);
    $display("test interrupt done");
    run_cfg(1'b1, 1'b1, 1, 3);
    run_cfg(1'b0, 1'b0, 15, 16);
    end_of_test();
  end
endmodule
`default_nettype wire
